// [pmw_pkg.sv]
package pmw_pkg;

	// ****************************************
	// Clock rates and timing
	// ****************************************
	localparam int CLK_HZ = 50_000_000;
	localparam int IRC_HZ = 4_000_000;
	localparam int HZ_PER_MHZ = 1_000_000;
	localparam int CLK_MHZ = CLK_HZ / HZ_PER_MHZ;
	localparam int IRC_MHZ = IRC_HZ / HZ_PER_MHZ;
	localparam int USB_CLK_MHZ = 48;
	localparam int CNT_W = 13;
	localparam int IRC_START_US = 60;
	localparam int FLASH_START_US = 100;
	// A least time: the clk count is us times whole MHz, with no rounding up.
	localparam logic [CNT_W-1:0] IRC_START_CYC = CNT_W'(IRC_START_US * CLK_MHZ);
	localparam logic [CNT_W-1:0] FLASH_IRC_CYC = CNT_W'(FLASH_START_US * IRC_MHZ);
	localparam logic [CNT_W-1:0] DS_IRC_WAKE_CYC = 13'h0004;
	localparam logic [CNT_W-1:0] DS_XTAL_WAKE_CYC = 13'h1000;
	localparam logic [CNT_W-1:0] PD_IRC_SETTLE_CYC = 13'h0004;
	localparam logic [CNT_W-1:0] XTAL_CHECK_CYC = 13'h1000;
	localparam logic [CNT_W-1:0] CNT_ONE = 13'h0001;

	// ****************************************
	// Modes, clock output and synchroniser slots
	// ****************************************
	localparam logic [1:0] MODE_SLEEP = 2'h0;
	localparam logic [1:0] MODE_DSLEEP = 2'h1;
	localparam logic [1:0] MODE_PDOWN = 2'h2;
	localparam logic [2:0] CLKOUT_CPU = 3'h0;
	localparam logic [2:0] CLKOUT_IRC = 3'h1;
	localparam logic [2:0] CLKOUT_XTAL = 3'h2;
	localparam logic [2:0] CLKOUT_RTC = 3'h3;
	localparam logic [2:0] CLKOUT_USB = 3'h4;
	localparam int SI_IRC = 0;
	localparam int SI_XTAL = 1;
	localparam int SI_RTC = 2;
	localparam int SI_USB = 3;
	localparam int SI_LOCK = 4;
	localparam int SI_ALARM = 5;
	localparam int SI_RSTPIN = 6;
	localparam int SI_DPD = 7;
	localparam int SI_N = 8;
	localparam int NIRQ = 8;
	localparam int NPER = 4;
	localparam int DIV_W = 2;
	localparam int PDIV_W = 3;
	localparam logic [PDIV_W-1:0] PDIV_ONE = 3'h1;

	typedef enum logic [2:0] {ST_RUN, ST_SLEEP, ST_DSLEEP, ST_PDOWN, ST_PD_START, ST_WAKE, ST_DPD} pmw_state_t;

	typedef struct packed {
		logic core_clk_en;
		logic irc_out_en;
		logic irc_pwr;
		logic xtal_pwr;
		logic main_pll_off;
		logic flash_pwr;
		logic pins_hold;
		logic rtc_osc_run;
		logic core_pwr;
	} pmw_pwr_t;

	typedef struct packed {
		logic cpu_on_xtal;
		logic xtal_ready;
		logic flash_ready;
		logic usb_pll_pwr;
		logic usb_on_usb_pll;
		logic div_clr;
		logic in_low_power;
		logic wake_evt;
	} pmw_stat_t;

endpackage : pmw_pkg

// [pmw_ctrl.sv]
`timescale 1ns/1ns
// Contract
// - USB PLL off and unpowered after reset; USB uses main PLL 48 MHz meanwhile.
// - USB PLL fed only from main oscillator, feeds only the USB block.
// - Clock output selects CPU, RC, crystal, RTC or USB clock.
// - After power-up or power-down wake, run from the 4 MHz RC oscillator.
// - Crystal use held off until checked after reset and power-down wake.
// - Exactly four reduced-power modes: sleep, deep-sleep, power-down, deep power-down.
// - Sleep gates only the core clock; any interrupt resumes.
// - Deep-sleep stops main oscillator and clocks, holds pins, keeps flash power.
// - Deep-sleep gates RC output but keeps it powered; RTC oscillator runs.
// - Deep-sleep entry turns PLL off and clears CPU and USB dividers.
// - Deep-sleep left only by reset or clockless wake interrupts.
// - Deep-sleep wake waits 4 RC cycles or 4096 crystal cycles.
// - Power-down also removes RC oscillator and flash power.
// - Power-down wake allows 60 us RC start then 4 RC cycles.
// - Flash timer counts RC cycles for 100 us, blocking flash until done.
// - Deep power-down entered only from RTC; only RTC and reset pin powered.
// - Deep power-down left only by reset pin or RTC alarm.
// - Interrupt controller hands an enabled, high-priority mask at clock-stopped entry.
// - Wake monitor wakes the CPU on any masked interrupt, without polling.
// - Each peripheral has its own divider and clock gate.
module pmw_ctrl
	import pmw_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic wfi_req,
	input wire logic [1:0] mode_sel,
	input wire logic xtal_en,
	input wire logic use_xtal,
	input wire logic usb_pll_en,
	input wire logic [2:0] clkout_sel,
	input wire logic [NIRQ-1:0] irq_pend,
	input wire logic [NIRQ-1:0] irq_wake_mask,
	input wire logic rtc_dpd_req,
	input wire logic rtc_alarm,
	input wire logic ext_reset_n,
	input wire logic irc_clk_in,
	input wire logic xtal_clk_in,
	input wire logic rtc_clk_in,
	input wire logic usb_clk_in,
	input wire logic usb_pll_lock,
	input wire logic [NPER-1:0] per_gate_en,
	input wire logic [NPER-1:0][DIV_W-1:0] per_div_sel,
	output pmw_pwr_t pwr,
	output pmw_stat_t stat,
	output logic clkout,
	output logic [NPER-1:0] per_clk_en
);

	// ****************************************
	// Helpers
	// ****************************************
	function automatic logic clocks_stopped(input pmw_state_t s);
		clocks_stopped = (s == ST_DSLEEP) || (s == ST_PDOWN) || (s == ST_PD_START) || (s == ST_WAKE) || (s == ST_DPD);
	endfunction : clocks_stopped

	function automatic logic [PDIV_W-1:0] div_last(input logic [DIV_W-1:0] sel);
		div_last = PDIV_W'((PDIV_ONE << sel) - PDIV_ONE);
	endfunction : div_last

	// ****************************************
	// Synchronisers for pins and foreign clocks
	// ****************************************
	// Sampling at 50 MHz resolves the crystal only up to about 25 MHz.
	logic [SI_N-1:0] async_in;
	logic [SI_N-1:0] sync1_ff;
	logic [SI_N-1:0] sync2_ff;
	logic [SI_N-1:0] sync3_ff;
	logic [SI_N-1:0] rise;

	assign async_in[SI_IRC] = irc_clk_in;
	assign async_in[SI_XTAL] = xtal_clk_in;
	assign async_in[SI_RTC] = rtc_clk_in;
	assign async_in[SI_USB] = usb_clk_in;
	assign async_in[SI_LOCK] = usb_pll_lock;
	assign async_in[SI_ALARM] = rtc_alarm;
	assign async_in[SI_RSTPIN] = ext_reset_n;
	assign async_in[SI_DPD] = rtc_dpd_req;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sync1_ff <= '0;
			sync2_ff <= '0;
			sync3_ff <= '0;
		end
		else
		begin
			sync1_ff <= async_in;
			sync2_ff <= sync1_ff;
			sync3_ff <= sync2_ff;
		end
	end

	assign rise = sync2_ff & ~sync3_ff;

	// ****************************************
	// Mode sequencer
	// ****************************************
	pmw_state_t state_ff;
	pmw_state_t nxt_state;
	logic [CNT_W-1:0] cnt_ff;
	logic [CNT_W-1:0] nxt_cnt;
	logic [NIRQ-1:0] mask_ff;
	logic from_xtal_ff;
	logic cpu_on_xtal_ff;
	logic wake_hit;
	logic irq_any;
	logic wake_tick;
	logic [CNT_W-1:0] wake_last;
	logic dpd_exit;
	logic entering;

	assign wake_hit = |(irq_pend & mask_ff);
	assign irq_any = |irq_pend;
	assign wake_tick = from_xtal_ff ? rise[SI_XTAL] : rise[SI_IRC];
	assign wake_last = from_xtal_ff ? (DS_XTAL_WAKE_CYC - CNT_ONE) : (DS_IRC_WAKE_CYC - CNT_ONE);
	assign dpd_exit = rise[SI_ALARM] | ~sync2_ff[SI_RSTPIN];
	assign entering = (state_ff == ST_RUN) && (nxt_state != ST_RUN);

	always_comb
	begin
		nxt_state = state_ff;
		nxt_cnt = cnt_ff;
		case (state_ff)
			ST_RUN:
			begin
				nxt_cnt = '0;
				if (sync2_ff[SI_DPD])
					nxt_state = ST_DPD;
				else if (wfi_req)
				begin
					case (mode_sel)
						MODE_DSLEEP: nxt_state = ST_DSLEEP;
						MODE_PDOWN: nxt_state = ST_PDOWN;
						default: nxt_state = ST_SLEEP;
					endcase
				end
			end
			ST_SLEEP:
			begin
				if (irq_any)
					nxt_state = ST_RUN;
			end
			ST_DSLEEP:
			begin
				if (wake_hit)
					nxt_state = ST_WAKE;
			end
			ST_PDOWN:
			begin
				if (wake_hit)
					nxt_state = ST_PD_START;
			end
			ST_PD_START:
			begin
				nxt_cnt = CNT_W'(cnt_ff + CNT_ONE);
				if (cnt_ff == IRC_START_CYC - CNT_ONE)
				begin
					nxt_state = ST_WAKE;
					nxt_cnt = '0;
				end
			end
			ST_WAKE:
			begin
				if (wake_tick)
				begin
					nxt_cnt = CNT_W'(cnt_ff + CNT_ONE);
					if (cnt_ff == wake_last)
						nxt_state = ST_RUN;
				end
			end
			ST_DPD:
			begin
				if (dpd_exit)
					nxt_state = ST_RUN;
			end
			default: nxt_state = ST_RUN;
		endcase
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_ff <= ST_RUN;
			cnt_ff <= '0;
		end
		else
		begin
			state_ff <= nxt_state;
			cnt_ff <= nxt_cnt;
		end
	end

	// The mask is a snapshot; later priority changes do not reach a sleeping core.
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			mask_ff <= '0;
			from_xtal_ff <= 1'b0;
		end
		else if (entering)
		begin
			mask_ff <= irq_wake_mask;
			from_xtal_ff <= (nxt_state == ST_DSLEEP) && cpu_on_xtal_ff;
		end
	end

	// ****************************************
	// Oscillator, flash and power gating
	// ****************************************
	logic xtal_pwr;
	logic flash_pwr;
	logic [CNT_W-1:0] xtal_cnt_ff;
	logic xtal_ready_ff;
	logic [CNT_W-1:0] flash_cnt_ff;
	logic flash_ready_ff;
	logic div_clr_ff;
	logic wake_evt_ff;
	logic usb_pll_pwr_ff;
	logic usb_on_pll_ff;

	assign xtal_pwr = xtal_en && ((state_ff == ST_RUN) || (state_ff == ST_SLEEP) || (state_ff == ST_WAKE));
	assign flash_pwr = (state_ff != ST_PDOWN) && (state_ff != ST_PD_START) && (state_ff != ST_DPD);

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			xtal_cnt_ff <= '0;
			xtal_ready_ff <= 1'b0;
		end
		else if (!xtal_pwr)
		begin
			xtal_cnt_ff <= '0;
			xtal_ready_ff <= 1'b0;
		end
		else if (!xtal_ready_ff && rise[SI_XTAL])
		begin
			xtal_cnt_ff <= CNT_W'(xtal_cnt_ff + CNT_ONE);
			xtal_ready_ff <= (xtal_cnt_ff == XTAL_CHECK_CYC - CNT_ONE);
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			flash_cnt_ff <= '0;
			flash_ready_ff <= 1'b0;
		end
		else if (!flash_pwr)
		begin
			flash_cnt_ff <= '0;
			flash_ready_ff <= 1'b0;
		end
		else if (!flash_ready_ff && rise[SI_IRC])
		begin
			flash_cnt_ff <= CNT_W'(flash_cnt_ff + CNT_ONE);
			flash_ready_ff <= (flash_cnt_ff == FLASH_IRC_CYC - CNT_ONE);
		end
	end

	// Software must still request the crystal; the gate only refuses an unchecked one.
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cpu_on_xtal_ff <= 1'b0;
			div_clr_ff <= 1'b0;
			wake_evt_ff <= 1'b0;
			usb_pll_pwr_ff <= 1'b0;
			usb_on_pll_ff <= 1'b0;
		end
		else
		begin
			cpu_on_xtal_ff <= use_xtal && xtal_ready_ff;
			div_clr_ff <= entering && ((nxt_state == ST_DSLEEP) || (nxt_state == ST_PDOWN));
			wake_evt_ff <= (state_ff != ST_RUN) && (nxt_state == ST_RUN);
			usb_pll_pwr_ff <= usb_pll_en && xtal_pwr && !clocks_stopped(state_ff);
			usb_on_pll_ff <= usb_pll_en && xtal_pwr && usb_pll_pwr_ff && sync2_ff[SI_LOCK];
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	pmw_pwr_t nxt_pwr;
	pmw_pwr_t pwr_ff;

	always_comb
	begin
		nxt_pwr.core_clk_en = (nxt_state == ST_RUN);
		nxt_pwr.irc_out_en = !clocks_stopped(nxt_state) || (nxt_state == ST_WAKE);
		nxt_pwr.irc_pwr = (nxt_state != ST_PDOWN) && (nxt_state != ST_DPD);
		nxt_pwr.xtal_pwr = xtal_en && ((nxt_state == ST_RUN) || (nxt_state == ST_SLEEP) || (nxt_state == ST_WAKE));
		nxt_pwr.main_pll_off = clocks_stopped(nxt_state);
		nxt_pwr.flash_pwr = (nxt_state != ST_PDOWN) && (nxt_state != ST_PD_START) && (nxt_state != ST_DPD);
		nxt_pwr.pins_hold = clocks_stopped(nxt_state);
		nxt_pwr.rtc_osc_run = 1'b1;
		nxt_pwr.core_pwr = (nxt_state != ST_DPD);
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			pwr_ff <= '0;
		else
			pwr_ff <= nxt_pwr;
	end

	assign pwr = pwr_ff;
	assign stat.cpu_on_xtal = cpu_on_xtal_ff;
	assign stat.xtal_ready = xtal_ready_ff;
	assign stat.flash_ready = flash_ready_ff;
	assign stat.usb_pll_pwr = usb_pll_pwr_ff;
	assign stat.usb_on_usb_pll = usb_on_pll_ff;
	assign stat.div_clr = div_clr_ff;
	assign stat.in_low_power = !pwr_ff.core_clk_en;
	assign stat.wake_evt = wake_evt_ff;

	// ****************************************
	// Clock output select
	// ****************************************
	logic nxt_clkout;
	logic clkout_ff;
	logic cpu_level;

	assign cpu_level = pwr_ff.core_clk_en && (cpu_on_xtal_ff ? sync2_ff[SI_XTAL] : sync2_ff[SI_IRC]);

	always_comb
	begin
		case (clkout_sel)
			CLKOUT_CPU: nxt_clkout = cpu_level;
			CLKOUT_IRC: nxt_clkout = sync2_ff[SI_IRC] && pwr_ff.irc_out_en;
			CLKOUT_XTAL: nxt_clkout = sync2_ff[SI_XTAL];
			CLKOUT_RTC: nxt_clkout = sync2_ff[SI_RTC];
			CLKOUT_USB: nxt_clkout = sync2_ff[SI_USB];
			default: nxt_clkout = 1'b0;
		endcase
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			clkout_ff <= 1'b0;
		else
			clkout_ff <= nxt_clkout;
	end

	assign clkout = clkout_ff;

	// ****************************************
	// Peripheral dividers and gates
	// ****************************************
	genvar gi;
	generate
		for (gi = 0; gi < NPER; gi++)
		begin : g_per
			logic [PDIV_W-1:0] pcnt_ff;
			logic pen_ff;
			logic run;
			logic hit;

			assign run = per_gate_en[gi] && !clocks_stopped(state_ff);
			assign hit = (pcnt_ff >= div_last(per_div_sel[gi]));

			always_ff @(posedge clk or negedge rst_n)
			begin
				if (!rst_n)
				begin
					pcnt_ff <= '0;
					pen_ff <= 1'b0;
				end
				else
				begin
					pcnt_ff <= (!run || hit) ? '0 : PDIV_W'(pcnt_ff + PDIV_ONE);
					pen_ff <= run && hit;
				end
			end

			assign per_clk_en[gi] = pen_ff;
		end
	endgenerate

endmodule : pmw_ctrl

// [pmw_ctrl_properties.sv]
`timescale 1ns/1ns
// ****
// Checker
// ****
module pmw_ctrl_properties
	import pmw_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic wfi_req,
	input wire logic [1:0] mode_sel,
	input wire logic [NIRQ-1:0] irq_pend,
	input wire logic [NIRQ-1:0] irq_wake_mask,
	input wire logic rtc_dpd_req,
	input wire pmw_pwr_t pwr,
	input wire pmw_stat_t stat
);
	logic [NIRQ-1:0] mask_ff;
	logic [1:0] mode_ff;
	logic xw_ff;
	int unsigned st_ff;
	wire run = pwr.core_clk_en;
	wire ds = pwr.core_pwr & pwr.irc_pwr & pwr.flash_pwr & ~pwr.irc_out_en;
	wire pd = pwr.core_pwr & ~pwr.irc_pwr;
	wire pds = pwr.core_pwr & pwr.irc_pwr & ~pwr.flash_pwr;
	wire hit = |(irq_pend & mask_ff);
	wire slp = ~run & pwr.core_pwr & (mode_ff[0] == mode_ff[1]);
	// The mask is taken only when the run state is left, as the controller hands it over then.
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			mask_ff <= '0;
			mode_ff <= 2'h0;
			xw_ff <= 1'b0;
			st_ff <= 0;
		end
		else
		begin
			if (run && wfi_req)
			begin
				mask_ff <= irq_wake_mask;
				mode_ff <= mode_sel;
				xw_ff <= stat.cpu_on_xtal;
			end
			st_ff <= pds ? st_ff + 1 : 0;
		end
	end
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	AST_USB_OFF: assert property (!pwr.xtal_pwr && $past(!pwr.xtal_pwr) |-> !stat.usb_pll_pwr)
		else $error("usb pll powered without crystal");
	AST_SLEEP_IN: assert property (run && wfi_req && mode_sel == MODE_SLEEP |=>
		!run && pwr.irc_out_en && pwr.flash_pwr && !pwr.main_pll_off)
		else $error("sleep entry wrong");
	AST_DS_IN: assert property (run && wfi_req && mode_sel == MODE_DSLEEP |=>
		ds && pwr.main_pll_off && pwr.pins_hold && !pwr.xtal_pwr && pwr.rtc_osc_run && stat.div_clr ##1 !stat.div_clr)
		else $error("deep sleep entry wrong");
	AST_PD_IN: assert property (run && wfi_req && mode_sel == MODE_PDOWN |=>
		pd && !pwr.flash_pwr && pwr.main_pll_off && pwr.pins_hold && stat.div_clr ##1 !stat.div_clr)
		else $error("power down entry wrong");
	AST_SLEEP_OUT: assert property (slp && irq_pend != 0 |=> run)
		else $error("sleep not left on interrupt");
	AST_DS_HOLD: assert property (ds && !hit |=> ds)
		else $error("deep sleep left without masked interrupt");
	AST_DS_WAKE: assert property (ds && hit && !xw_ff |=> (pwr.irc_out_en && !run)[*8] ##[1:120] run)
		else $error("deep sleep wake timing wrong");
	AST_PD_WAIT: assert property ($rose(pwr.flash_pwr) && $past(pwr.irc_pwr) |-> st_ff + 2 >= IRC_START_CYC)
		else $error("rc start time too short");
	AST_DPD_IN: assert property ($fell(pwr.core_pwr) |-> $past(rtc_dpd_req, 2) && !pwr.flash_pwr && !pwr.irc_pwr && pwr.rtc_osc_run)
		else $error("deep power down entry wrong");
	CV_SLEEP: cover property (run && wfi_req && mode_sel == MODE_SLEEP);
	CV_DS_WAKE: cover property (ds && hit);
	CV_DPD: cover property ($fell(pwr.core_pwr));
endmodule : pmw_ctrl_properties

// [pmw_cpu_model.sv]
`timescale 1ns/1ns
// ****
// Core and interrupt controller
// ****
module pmw_cpu_model
	import pmw_pkg::*;
(
	input wire logic clk,
	input wire pmw_stat_t stat,
	output logic wfi_req,
	output logic [1:0] mode_sel,
	output logic [NIRQ-1:0] irq_wake_mask,
	output logic xtal_en,
	output logic use_xtal
);
	initial
	begin
		wfi_req = 1'b0;
		mode_sel = MODE_SLEEP;
		irq_wake_mask = '0;
		xtal_en = 1'b0;
		use_xtal = 1'b0;
	end
	// Only called while the core runs, so the request is never lost.
	task automatic enter(input logic [1:0] m, input logic [NIRQ-1:0] k);
		@(negedge clk);
		mode_sel = m;
		irq_wake_mask = k;
		wfi_req = 1'b1;
		@(negedge clk);
		wfi_req = 1'b0;
	endtask : enter
	task automatic crystal_on();
		@(negedge clk);
		xtal_en = 1'b1;
		while (stat.xtal_ready !== 1'b1) @(negedge clk);
		use_xtal = 1'b1;
	endtask : crystal_on
	task automatic crystal_off();
		@(negedge clk);
		use_xtal = 1'b0;
		xtal_en = 1'b0;
	endtask : crystal_off
endmodule : pmw_cpu_model

// [pmw_ctrl_test.sv]
`timescale 1ns/1ns
// ****
// Testbench
// ****
module pmw_ctrl_test
	import pmw_pkg::*;
;
	logic clk = 1'b0, rst_n = 1'b0, internal_rc_osc = 1'b0, xtal = 1'b0, rtc = 1'b0, usb = 1'b0;
	logic usb_pll_en = 1'b0, rtc_dpd_req = 1'b0, rtc_alarm = 1'b0, ext_reset_n = 1'b1;
	logic [2:0] clkout_sel = CLKOUT_CPU;
	logic [NIRQ-1:0] irq_pend = '0;
	logic [NPER-1:0] gate = '0;
	logic [NPER-1:0][DIV_W-1:0] dsel = '0;
	logic wfi_req, xtal_en, use_xtal, clkout;
	logic [1:0] mode_sel;
	logic [NIRQ-1:0] wmask;
	logic [NPER-1:0] per_clk_en;
	pmw_pwr_t pwr;
	pmw_stat_t stat;
	int n_errors = 0, n_checks = 0, cyc = 0, n, i, k, e;
	int cnt [NPER];
	int rate [5] = '{250, 80, 250, 20, 40};
	int lo [3] = '{16380, 35, 3030};
	int hi [3] = '{16420, 60, 3080};
	logic [1:0] mds [3] = '{MODE_DSLEEP, MODE_DSLEEP, MODE_PDOWN};
	integer seed = 32'h3afded51;
	always #10 clk = ~clk;
	always #125 internal_rc_osc = ~internal_rc_osc;
	always #40 xtal = ~xtal;
	always #250 usb = ~usb;
	always #500 rtc = ~rtc;
	pmw_cpu_model cpu (.clk(clk), .stat(stat), .wfi_req(wfi_req), .mode_sel(mode_sel),
		.irq_wake_mask(wmask), .xtal_en(xtal_en), .use_xtal(use_xtal));
	pmw_ctrl dut (.clk(clk), .rst_n(rst_n), .wfi_req(wfi_req), .mode_sel(mode_sel), .xtal_en(xtal_en),
		.use_xtal(use_xtal), .usb_pll_en(usb_pll_en), .clkout_sel(clkout_sel), .irq_pend(irq_pend),
		.irq_wake_mask(wmask), .rtc_dpd_req(rtc_dpd_req), .rtc_alarm(rtc_alarm), .ext_reset_n(ext_reset_n),
		.irc_clk_in(internal_rc_osc), .xtal_clk_in(xtal), .rtc_clk_in(rtc), .usb_clk_in(usb), .usb_pll_lock(usb_pll_en),
		.per_gate_en(gate), .per_div_sel(dsel), .pwr(pwr), .stat(stat), .clkout(clkout), .per_clk_en(per_clk_en));
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("wrong value %s expected %0h seen %0h", nm, exp, seen);
		end
	endtask : chk
	// Counts are judged within a window, since the clocks are unrelated in phase.
	function automatic int fit(input int v, input int a, input int b);
		return (v >= a && v <= b) ? a : v;
	endfunction : fit
	task automatic wake(input logic [NIRQ-1:0] b, output int c);
		irq_pend = b;
		for (c = 0; c < 20000 && pwr.core_clk_en !== 1'b1; c++) @(negedge clk);
		irq_pend = '0;
	endtask : wake
	task automatic conclude();
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : conclude
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 80000)
		begin
			n_errors++;
			conclude();
		end
	end
	initial
	begin
		repeat (20) @(negedge clk);
		rst_n = 1'b1;
		@(negedge clk);
		chk("usb_pll_pwr", stat.usb_pll_pwr, 0);
		chk("usb_on_usb_pll", stat.usb_on_usb_pll, 0);
		chk("cpu_on_xtal", stat.cpu_on_xtal, 0);
		chk("irc_out_en", pwr.irc_out_en, 1);
		for (n = 1; n < 6000 && stat.flash_ready !== 1'b1; n++) @(negedge clk);
		chk("flash wait", fit(n, 4985, 5020), 4985);
		fork
			cpu.crystal_on();
		join_none
		for (n = 0; n < 20000 && stat.cpu_on_xtal !== 1'b1; n++) @(negedge clk);
		chk("crystal wait", fit(n, 16380, 16400), 16380);
		usb_pll_en = 1'b1;
		repeat (8) @(negedge clk);
		chk("usb_pll_pwr", stat.usb_pll_pwr, 1);
		chk("usb_on_usb_pll", stat.usb_on_usb_pll, 1);
		$display("clock start done");
		for (k = 0; k < 5; k++)
		begin
			clkout_sel = k[2:0];
			repeat (8) @(negedge clk);
			n = 0;
			repeat (1000)
			begin
				i = clkout;
				@(negedge clk);
				n += (clkout & ~i);
			end
			chk("clkout", fit(n, rate[k] - 2, rate[k] + 2), rate[k] - 2);
		end
		$display("clock out done");
		gate = $random(seed);
		dsel = $random(seed);
		cpu.enter(($random(seed) & 1) ? 2'h3 : MODE_SLEEP, '0);
		chk("in_low_power", stat.in_low_power, 1);
		cnt = '{default: 0};
		repeat (256)
		begin
			@(negedge clk);
			for (i = 0; i < NPER; i++) cnt[i] += per_clk_en[i];
		end
		for (i = 0; i < NPER; i++)
		begin
			e = gate[i] ? (256 >> dsel[i]) : 0;
			chk("per_clk_en", fit(cnt[i], e - 1, e + 1), e - 1);
		end
		wake(8'h01 << ($random(seed) & 7), n);
		chk("sleep wake", fit(n, 1, 3), 1);
		chk("wake_evt", stat.wake_evt, 1);
		$display("sleep done");
		for (k = 0; k < 3; k++)
		begin
			if (k == 1)
				cpu.crystal_off();
			repeat (8) @(negedge clk);
			cpu.enter(mds[k], 8'h0f);
			irq_pend = 8'hf0;
			repeat (50) @(negedge clk);
			chk("in_low_power", stat.in_low_power, 1);
			wake(8'h01 << ($random(seed) & 3), n);
			chk("wake time", fit(n, lo[k], hi[k]), lo[k]);
			chk("wake_evt", stat.wake_evt, 1);
			chk("flash_ready", stat.flash_ready, k < 2);
		end
		$display("deep sleep and power down done");
		for (k = 0; k < 2; k++)
		begin
			rtc_dpd_req = 1'b1;
			repeat (8) @(negedge clk);
			chk("core_pwr", pwr.core_pwr, 0);
			rtc_dpd_req = 1'b0;
			irq_pend = 8'hff;
			repeat (20) @(negedge clk);
			chk("core_pwr", pwr.core_pwr, 0);
			irq_pend = '0;
			if (k == 0)
				rtc_alarm = 1'b1;
			else
				ext_reset_n = 1'b0;
			repeat (8) @(negedge clk);
			chk("core_pwr", pwr.core_pwr, 1);
			rtc_alarm = 1'b0;
			ext_reset_n = 1'b1;
		end
		$display("deep power down done");
		conclude();
	end
endmodule : pmw_ctrl_test
bind pmw_ctrl pmw_ctrl_properties u_props (.clk(clk), .rst_n(rst_n), .wfi_req(wfi_req), .mode_sel(mode_sel),
	.irq_pend(irq_pend), .irq_wake_mask(irq_wake_mask), .rtc_dpd_req(rtc_dpd_req), .pwr(pwr), .stat(stat));
